// ---- ufc_pkg.sv ----
// constants, field layout and carrier type for the uart fifo setup block
// assumes a 32-bit classic wishbone bus with byte addresses
package ufc_pkg;
  // register byte offsets
  localparam logic [3:0] SETUP_ADDR = 4'h0;
  localparam logic [3:0] ENH_ADDR = 4'h4;
  localparam logic [3:0] STAT_ADDR = 4'h8;
  // setup register fields
  localparam int RX_TRIG_LSB = 6;
  localparam int TX_TRIG_LSB = 4;
  localparam int DMA_BIT = 3;
  localparam int TX_FLUSH_BIT = 2;
  localparam int RX_FLUSH_BIT = 1;
  localparam int ENABLE_BIT = 0;
  // enhanced feature register field
  localparam int ENH_ENABLE_BIT = 4;
  localparam logic [7:0] ENH_RESET = 8'h00;
  // status register fields
  localparam int ST_RXSEL_LSB = 2;
  localparam int ST_TXSEL_LSB = 4;
  localparam int ST_RXHIT_BIT = 6;
  localparam int ST_TXHIT_BIT = 7;
  // trigger select codes
  localparam logic [1:0] TRIG_SEL_RESET = 2'h0;
  // receive trigger levels in characters
  localparam logic [6:0] RX_LVL0 = 7'h08;
  localparam logic [6:0] RX_LVL1 = 7'h10;
  localparam logic [6:0] RX_LVL2 = 7'h38;
  localparam logic [6:0] RX_LVL3 = 7'h3C;
  // transmit trigger levels in free spaces
  localparam logic [6:0] TX_LVL0 = 7'h08;
  localparam logic [6:0] TX_LVL1 = 7'h10;
  localparam logic [6:0] TX_LVL2 = 7'h20;
  localparam logic [6:0] TX_LVL3 = 7'h38;

  typedef struct packed {
    logic [1:0] rxTriggerSelect;
    logic [1:0] txTriggerSelect;
    logic dmaModeSelect;
    logic fifoEnableBit;
  } ufc_setup_type;

  localparam ufc_setup_type SETUP_RESET = '{2'h0, 2'h0, 1'b0, 1'b0};
endpackage : ufc_pkg

// ---- ufc_fifo_setup.sv ----
// fifo setup control for one uart channel, wishbone classic slave
// assumes fill and free counts come from fifo logic on clk_sys
//
// What this block does
// - the setup register is write only and reading its address gives zero.
// - bits 7:6 pick the receive trigger of 8, 16, 56 or 60 characters.
// - bits 5:4 pick the transmit trigger of 8, 16, 32 or 56 free spaces.
// - the tx trigger field is taken and applied only while enhanced is on.
// - bit 3 selects dma mode 0 or dma mode 1.
// - writing 1 to bit 2 flushes the transmit fifo once and the bit self clears.
// - writing 1 to bit 1 flushes the receive fifo once and the bit self clears.
// - bit 0 enables both fifos, and reset leaves them disabled with no flush.
// - with fifos disabled the receiver keeps each character in slot zero only.
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ufc_fifo_setup #(
  parameter int COUNT_W = 7
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEnable,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [COUNT_W-1:0] rxFillCount,
  input wire logic [COUNT_W-1:0] txFreeCount,
  output logic fifoEnable,
  output logic dmaMode,
  output logic txFifoFlush,
  output logic rxFifoFlush,
  output logic rxSingleSlot,
  output logic [COUNT_W-1:0] rxTriggerLevel,
  output logic [COUNT_W-1:0] txTriggerLevel,
  output logic rxTriggerHit,
  output logic txTriggerHit
);
  ufc_pkg::ufc_setup_type setup, next_setup;
  logic [7:0] enhancedFeatureReg, next_enhancedFeatureReg;
  logic [31:0] next_wb_dat_o;
  logic next_wb_ack_o;
  logic next_txFifoFlush, next_rxFifoFlush;
  logic [COUNT_W-1:0] next_rxTriggerLevel, next_txTriggerLevel;
  logic next_rxTriggerHit, next_txTriggerHit;
  logic enhOn, writeLane, request;
  logic [1:0] txSelApplied;
  logic [7:0] statusByte;
  logic setupSel;
  logic enhSel;
  logic statSel;
  logic readReq;

  function automatic logic [COUNT_W-1:0] rxLevel(input logic [1:0] sel);
    logic [6:0] lvl;
    lvl = ufc_pkg::RX_LVL0;
    case (sel)
      2'h1: lvl = ufc_pkg::RX_LVL1;
      2'h2: lvl = ufc_pkg::RX_LVL2;
      2'h3: lvl = ufc_pkg::RX_LVL3;
      default: lvl = ufc_pkg::RX_LVL0;
    endcase
    return COUNT_W'(lvl);
  endfunction : rxLevel

  function automatic logic [COUNT_W-1:0] txLevel(input logic [1:0] sel);
    logic [6:0] lvl;
    lvl = ufc_pkg::TX_LVL0;
    case (sel)
      2'h1: lvl = ufc_pkg::TX_LVL1;
      2'h2: lvl = ufc_pkg::TX_LVL2;
      2'h3: lvl = ufc_pkg::TX_LVL3;
      default: lvl = ufc_pkg::TX_LVL0;
    endcase
    return COUNT_W'(lvl);
  endfunction : txLevel

  // bus handshake: one registered ack per request, data only on reads
  // a registered ack costs a cycle of latency but keeps the bus path short
  // clkEnable low freezes ack too, so a master simply waits longer
  always_comb begin
    // ack held low one cycle between requests keeps every access single
    request = wb_cyc_i && wb_stb_i && !wb_ack_o;
    readReq = request && !wb_we_i;
    setupSel = wb_adr_i == ufc_pkg::SETUP_ADDR;
    enhSel = wb_adr_i == ufc_pkg::ENH_ADDR;
    statSel = wb_adr_i == ufc_pkg::STAT_ADDR;
    next_wb_ack_o = request;
    next_wb_dat_o = 32'h0000_0000;

    if (readReq) begin
      if (setupSel) begin
        // write only: software cannot read back its own setup
        next_wb_dat_o = 32'h0000_0000;
      end else if (enhSel) begin
        next_wb_dat_o[7:0] = enhancedFeatureReg;
      end else if (statSel) begin
        next_wb_dat_o[7:0] = statusByte;
      end else begin
        // unmapped reads answer zero rather than stall the bus
        next_wb_dat_o = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else if (clkEnable) begin
      // data falls back to zero in every cycle that answers no read
      wb_dat_o <= next_wb_dat_o;
      wb_ack_o <= next_wb_ack_o;
    end
  end

  // status view of what is applied, not of what was last written
  // the tx select shown is the applied one, so it reads 0 with enhanced off
  always_comb begin
    statusByte = 8'h00;
    statusByte[ufc_pkg::ENABLE_BIT] = setup.fifoEnableBit;
    // the dma bit sits just above enable in the status byte
    statusByte[ufc_pkg::DMA_BIT - 2] = setup.dmaModeSelect;
    statusByte[ufc_pkg::ST_RXSEL_LSB +: 2] = setup.rxTriggerSelect;
    statusByte[ufc_pkg::ST_TXSEL_LSB +: 2] = txSelApplied;
    statusByte[ufc_pkg::ST_RXHIT_BIT] = rxTriggerHit;
    statusByte[ufc_pkg::ST_TXHIT_BIT] = txTriggerHit;
  end

  // setup storage, enhanced feature register and flush strobes
  // flush bits keep no state, so a read never shows a pending flush
  // rx select, dma and enable are taken whatever the enhanced bit says
  always_comb begin
    enhOn = enhancedFeatureReg[ufc_pkg::ENH_ENABLE_BIT];
    // byte lane zero carries every 8-bit register
    writeLane = request && wb_we_i && wb_sel_i[0];
    next_setup = setup;
    next_enhancedFeatureReg = enhancedFeatureReg;
    // flush strobes last one cycle so the bits read back as cleared
    next_txFifoFlush = 1'b0;
    next_rxFifoFlush = 1'b0;

    if (writeLane && setupSel) begin
      next_setup.rxTriggerSelect =
        wb_dat_i[ufc_pkg::RX_TRIG_LSB +: 2];
      // tx field needs enhanced functions on, else the old value stays
      if (enhOn) begin
        next_setup.txTriggerSelect =
          wb_dat_i[ufc_pkg::TX_TRIG_LSB +: 2];
      end
      next_setup.dmaModeSelect = wb_dat_i[ufc_pkg::DMA_BIT];
      next_txFifoFlush = wb_dat_i[ufc_pkg::TX_FLUSH_BIT];
      next_rxFifoFlush = wb_dat_i[ufc_pkg::RX_FLUSH_BIT];
      next_setup.fifoEnableBit = wb_dat_i[ufc_pkg::ENABLE_BIT];
    end else if (writeLane && enhSel) begin
      next_enhancedFeatureReg = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      setup <= ufc_pkg::SETUP_RESET;
      enhancedFeatureReg <= ufc_pkg::ENH_RESET;
      fifoEnable <= 1'b0;
      dmaMode <= 1'b0;
      txFifoFlush <= 1'b0;
      rxFifoFlush <= 1'b0;
      rxSingleSlot <= 1'b1;
    end else if (clkEnable) begin
      setup <= next_setup;
      enhancedFeatureReg <= next_enhancedFeatureReg;
      fifoEnable <= next_setup.fifoEnableBit;
      dmaMode <= next_setup.dmaModeSelect;
      txFifoFlush <= next_txFifoFlush;
      rxFifoFlush <= next_rxFifoFlush;
      // single slot follows enable so the receiver never sees both modes
      rxSingleSlot <= !next_setup.fifoEnableBit;
    end
  end

  // trigger levels and threshold compares for dma and interrupt logic
  // levels are registered, but the compares read the unregistered next levels
  always_comb begin
    // stored tx field stays but falls back to the reset level when off
    txSelApplied = enhOn ? setup.txTriggerSelect
                         : ufc_pkg::TRIG_SEL_RESET;
    next_rxTriggerLevel = rxLevel(setup.rxTriggerSelect);
    next_txTriggerLevel = txLevel(txSelApplied);

    // compare lags the count by one cycle, fine for trigger use
    // an equal count is a hit, so a threshold reached exactly is seen
    next_rxTriggerHit = rxFillCount >= next_rxTriggerLevel;
    next_txTriggerHit = txFreeCount >= next_txTriggerLevel;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxTriggerLevel <= COUNT_W'(ufc_pkg::RX_LVL0);
      txTriggerLevel <= COUNT_W'(ufc_pkg::TX_LVL0);
      rxTriggerHit <= 1'b0;
      txTriggerHit <= 1'b0;
    end else if (clkEnable) begin
      rxTriggerLevel <= next_rxTriggerLevel;
      txTriggerLevel <= next_txTriggerLevel;
      rxTriggerHit <= next_rxTriggerHit;
      txTriggerHit <= next_txTriggerHit;
    end
  end
endmodule : ufc_fifo_setup
`default_nettype wire

// ---- ufc_fifo_model.sv ----
// fifo fill model on the far side of the flush outputs
// assumes flush pulses last one clk_sys cycle
`timescale 1ns/1ns
`default_nettype none
module ufc_fifo_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic txFifoFlush,
  input wire logic rxFifoFlush,
  output logic [6:0] rxFillCount,
  output logic [6:0] txFreeCount
);
  // rx fills to 64 and tx drains to 0, one step per cycle, so both triggers get crossed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst || rxFifoFlush) rxFillCount <= 7'h00;
    else if (rxFillCount < 7'h40) rxFillCount <= rxFillCount + 7'h01;
    if (rst || txFifoFlush) txFreeCount <= 7'h40;
    else if (txFreeCount > 7'h00) txFreeCount <= txFreeCount - 7'h01;
  end
endmodule : ufc_fifo_model
`default_nettype wire

// ---- ufc_fifo_setup_chk.sv ----
// assertions on the bus and control ports of the setup block
// assumes clkEnable held high
`timescale 1ns/1ns
`default_nettype none
module ufc_fifo_setup_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic fifoEnable,
  input wire logic dmaMode,
  input wire logic txFifoFlush,
  input wire logic rxFifoFlush,
  input wire logic rxSingleSlot
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr = req && wb_we_i && wb_sel_i[0]
    && wb_adr_i == ufc_pkg::SETUP_ADDR;
  wire logic rd = req && !wb_we_i && wb_adr_i == ufc_pkg::SETUP_ADDR;
  sequence ackPulse; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence txPulse; txFifoFlush ##1 !txFifoFlush; endsequence
  sequence rxPulse; rxFifoFlush ##1 !rxFifoFlush; endsequence
  AST_ACK: assert property (req |=> ackPulse) else $error("ack not a pulse");
  AST_RDZ: assert property (rd |=> wb_dat_o == 32'h0)
    else $error("setup read not zero");
  AST_TXF: assert property (wr && wb_dat_i[2] |=> txPulse)
    else $error("tx flush pulse wrong");
  AST_RXF: assert property (wr && wb_dat_i[1] |=> rxPulse)
    else $error("rx flush pulse wrong");
  AST_NOF: assert property (!(wr && wb_dat_i[2]) |=> !txFifoFlush)
    else $error("stray tx flush");
  AST_EN: assert property (wr |=> fifoEnable == $past(wb_dat_i[0]))
    else $error("enable not taken");
  AST_DMA: assert property (wr |=> dmaMode == $past(wb_dat_i[3]))
    else $error("dma mode not taken");
  AST_SLOT: assert property (rxSingleSlot == !fifoEnable)
    else $error("single slot wrong");
endmodule : ufc_fifo_setup_chk
bind ufc_fifo_setup ufc_fifo_setup_chk ufc_fifo_setup_chk_i (.*);
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the fifo setup block
// assumes the fifo model answers the flush pulses
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys, rst, cyc, wbWe, ack, fen, dma, txFl, rxFl, slot;
  logic rxHit, txHit;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [6:0] rxFill, txFree, rxLvl, txLvl;
  int errTotal = 0, numChecks = 0;
  ufc_fifo_setup ufc_fifo_setup_i (.clk_sys, .rst, .clkEnable(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(wbWe), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rxFillCount(rxFill), .txFreeCount(txFree), .fifoEnable(fen),
    .dmaMode(dma), .txFifoFlush(txFl), .rxFifoFlush(rxFl),
    .rxSingleSlot(slot), .rxTriggerLevel(rxLvl), .txTriggerLevel(txLvl),
    .rxTriggerHit(rxHit), .txTriggerHit(txHit));
  ufc_fifo_model ufc_fifo_model_i (.clk_sys, .rst, .txFifoFlush(txFl),
    .rxFifoFlush(rxFl), .rxFillCount(rxFill), .txFreeCount(txFree));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    wbWe <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask : bus
  task automatic rxTrigger;
    logic [6:0] lvl[4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
    chk(slot, 1'b1);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, ufc_pkg::SETUP_ADDR, {c[1:0], 2'h0, c[0], 3'h1});
      @(posedge clk_sys);
      chk(rxLvl, lvl[c]);
      chk(dma, c[0]);
      chk(fen, 1'b1);
    end
    bus(1'b0, ufc_pkg::SETUP_ADDR, 8'h00);
    chk(q, 32'h0);
  endtask : rxTrigger
  task automatic txTrigger;
    logic [6:0] lvl[4] = '{7'h08, 7'h10, 7'h20, 7'h38};
    bus(1'b1, ufc_pkg::SETUP_ADDR, 8'h31);
    chk(txLvl, lvl[0]);
    bus(1'b1, ufc_pkg::ENH_ADDR, 8'h10);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, ufc_pkg::SETUP_ADDR, {2'h0, c[1:0], 4'h1});
      @(posedge clk_sys);
      chk(txLvl, lvl[c]);
    end
    bus(1'b1, ufc_pkg::ENH_ADDR, 8'h00);
    bus(1'b1, ufc_pkg::SETUP_ADDR, 8'h01);
    @(posedge clk_sys);
    chk(txLvl, lvl[0]);
  endtask : txTrigger
  task automatic flushAll;
    bus(1'b1, ufc_pkg::SETUP_ADDR, 8'h07);
    repeat (2) @(posedge clk_sys);
    chk(rxHit, 1'b0);
    chk(txHit, 1'b1);
    repeat (70) @(posedge clk_sys);
    chk(rxHit, 1'b1);
    chk(txHit, 1'b0);
  endtask : flushAll
  task automatic printVerdict;
    if (errTotal == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : printVerdict
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, cyc, wbWe, adr, wdat} = {3'b100, 4'h0, 32'h0};
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rxTrigger();
    txTrigger();
    flushAll();
    printVerdict();
  end
  // the whole run needs about 130 cycles; this leaves a wide margin
  initial begin
    repeat (3000) @(posedge clk_sys);
    errTotal++;
    printVerdict();
  end
endmodule : tb_top
`default_nettype wire
